// ===== core/sadcs_pkg.sv
// Shared constants and carrier types of the converter serial port block
package sadcs_pkg;

  // ----------------------------------------------------------------
  // Clock rates and derived counts
  // ----------------------------------------------------------------
  localparam int MCLK_HZ          = 125_000_000;
  localparam int CONV_CLK_HZ      = 2_500_000;
  localparam int CONV_CLK_HALF    = MCLK_HZ / (2 * CONV_CLK_HZ);
  localparam int CONV_CYCLES_DFLT = 100;

  // ----------------------------------------------------------------
  // Frame layout, counted in serial clocks
  // ----------------------------------------------------------------
  localparam logic [4:0] BIT_INSTR_LAST  = 5'h07;
  localparam logic [4:0] BIT_DATA_LAST   = 5'h0F;
  localparam logic [4:0] BIT_SHIFT_LAST  = 5'h16;
  localparam logic [4:0] BIT_DIRECT_LAST = 5'h17;

  // ----------------------------------------------------------------
  // Register offsets and instruction codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_NONE        = 3'h0;
  localparam logic [2:0] ADDR_PIN_LEVELS  = 3'h5;
  localparam logic [2:0] ADDR_DIRECTION   = 3'h6;
  localparam logic [2:0] ADDR_REF_OSC     = 3'h7;
  localparam logic [7:0] INSTR_WR_LEVELS  = 8'h06;
  localparam logic [7:0] INSTR_WR_DIR     = 8'h05;
  localparam logic [7:0] INSTR_WR_REF_OSC = 8'h07;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int INSTR_DIRECT_BIT = 7;
  localparam int REF_VSEL_B_BIT   = 0;
  localparam int REF_VSEL_A_BIT   = 1;
  localparam int BUFFER_ON_BIT    = 2;
  localparam int REFERENCE_ON_BIT = 3;
  localparam int OSC_POWER_BIT    = 4;
  localparam int OSC_AS_REF_BIT   = 5;
  localparam int CMD_GAIN_LSB     = 4;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } sadcs_reg_write_t;

  typedef struct packed {
    logic [11:0] code;
    logic [2:0]  zero;
    logic        overRange;
  } sadcs_result_t;

endpackage : sadcs_pkg

// ===== core/sadcs_fifo.sv
// Single-clock result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sadcs_fifo
  import sadcs_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr + 1'b1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr + 1'b1);
      end
      if (push && !pop) begin
        count <= (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
        count <= (AW+1)'(count - 1'b1);
      end
    end
  end

endmodule : sadcs_fifo

`default_nettype wire

// ===== core/sadcs_converter_port.sv
// Converter side: serial port, configuration registers and conversion engine
`timescale 1ns/1ps
`default_nettype none

module sadcs_converter_port
  import sadcs_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DFLT,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclk,
  input  wire logic        frameSel_b,
  input  wire logic        din,
  output logic             dout,
  output logic             busy,
  input  wire logic [11:0] analogCode,
  output logic [3:0]       ioOut,
  output logic [3:0]       ioOe,
  output logic             convClkOut,
  output logic             oscAsRef,
  output logic             referenceOn,
  output logic             bufferOn,
  output logic [1:0]       refVoltSel,
  output logic             fullScale2v5,
  output logic [3:0]       convChannel,
  output logic [2:0]       convGain
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [2:0] decodeAddr(input logic [7:0] instr);
    unique case (instr)
      INSTR_WR_LEVELS:  decodeAddr = ADDR_PIN_LEVELS;
      INSTR_WR_DIR:     decodeAddr = ADDR_DIRECTION;
      INSTR_WR_REF_OSC: decodeAddr = ADDR_REF_OSC;
      default:          decodeAddr = ADDR_NONE;
    endcase
  endfunction : decodeAddr

  // ----------------------------------------------------------------
  // Link domain (serial clock)
  // ----------------------------------------------------------------
  // Frame select high clears the frame position; a stopped clock is harmless
  logic             linkRst_b;
  logic [15:0]      readyWord;
  logic             pubToggle;
  logic [4:0]       bitCnt;
  logic [7:0]       inSh;
  logic [7:0]       nextByte;
  logic             isDirect;
  logic [7:0]       regInstr;
  logic [15:0]      outSh;
  logic             outPhase;
  logic [7:0]       cmdByte;
  logic             cmdToggle;
  sadcs_reg_write_t wrReq;
  logic             wrToggle;
  logic             ackToggle;
  logic             pubS1;
  logic             pubS2;
  logic             fresh;
  logic             instrDone;

  assign linkRst_b = rst_b && !frameSel_b;
  assign nextByte  = {inSh[6:0], din};
  assign instrDone = (bitCnt == BIT_INSTR_LAST);
  assign fresh     = (pubS2 != ackToggle);

  always_ff @(posedge sclk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      bitCnt   <= '0;
      isDirect <= 1'b0;
      inSh     <= '0;
      regInstr <= '0;
    end else begin
      inSh <= nextByte;
      if (isDirect && bitCnt == BIT_DIRECT_LAST) begin
        bitCnt <= '0;
      end else begin
        bitCnt <= 5'(bitCnt + 1'b1);
      end
      if (instrDone) begin
        isDirect <= nextByte[INSTR_DIRECT_BIT];
        regInstr <= nextByte;
      end
    end
  end

  // Result shifter: loaded on the last command bit, shifted out on falling edges
  always_ff @(posedge sclk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      outSh    <= WORD_ZERO;
      outPhase <= 1'b0;
    end else if (instrDone && nextByte[INSTR_DIRECT_BIT]) begin
      outSh    <= fresh ? readyWord : WORD_ZERO;
      outPhase <= 1'b1;
    end else if (outPhase) begin
      if (bitCnt <= BIT_SHIFT_LAST) begin
        outSh <= {outSh[14:0], 1'b0};
      end
      if (bitCnt == BIT_DIRECT_LAST) begin
        outPhase <= 1'b0;
      end
    end
  end

  always_ff @(negedge sclk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      dout <= 1'b0;
    end else begin
      dout <= outPhase && outSh[15];
    end
  end

  // Crossing state lives on the plain reset so it survives frame gaps.
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      cmdByte   <= '0;
      cmdToggle <= 1'b0;
      ackToggle <= 1'b0;
      wrReq     <= '0;
      wrToggle  <= 1'b0;
      pubS1     <= 1'b0;
      pubS2     <= 1'b0;
    end else begin
      pubS1 <= pubToggle;
      pubS2 <= pubS1;
      if (linkRst_b && instrDone && nextByte[INSTR_DIRECT_BIT]) begin
        cmdByte   <= nextByte;
        cmdToggle <= !cmdToggle;
        if (fresh) begin
          ackToggle <= !ackToggle;
        end
      end
      if (linkRst_b && bitCnt == BIT_DATA_LAST && !isDirect
          && decodeAddr(regInstr) != ADDR_NONE) begin
        wrReq.addr <= decodeAddr(regInstr);
        wrReq.data <= nextByte;
        wrToggle   <= !wrToggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: crossings, configuration and conversion clock
  // ----------------------------------------------------------------
  logic        wrS1;
  logic        wrS2;
  logic        wrS3;
  logic        cmdS1;
  logic        cmdS2;
  logic        cmdS3;
  logic        ackS1;
  logic        ackS2;
  logic [11:0] codeS1;
  logic [11:0] codeS2;
  logic        wrEvent;
  logic        cmdEvent;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {wrS1, wrS2, wrS3}    <= '0;
      {cmdS1, cmdS2, cmdS3} <= '0;
      {ackS1, ackS2}        <= '0;
      codeS1                <= '0;
      codeS2                <= '0;
    end else begin
      {wrS1, wrS2, wrS3}    <= {wrToggle, wrS1, wrS2};
      {cmdS1, cmdS2, cmdS3} <= {cmdToggle, cmdS1, cmdS2};
      {ackS1, ackS2}        <= {ackToggle, ackS1};
      codeS1                <= analogCode;
      codeS2                <= codeS1;
    end
  end

  assign wrEvent  = wrS2 ^ wrS3;
  assign cmdEvent = cmdS2 ^ cmdS3;

  logic [7:0] digitalIoPinLevels;
  logic [7:0] digitalIoDirection;
  logic [7:0] referenceOscillatorSetup;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      digitalIoPinLevels       <= REG_RESET;
      digitalIoDirection       <= REG_RESET;
      referenceOscillatorSetup <= REG_RESET;
    end else if (wrEvent) begin
      unique case (wrReq.addr)
        ADDR_PIN_LEVELS: digitalIoPinLevels       <= wrReq.data;
        ADDR_DIRECTION:  digitalIoDirection       <= wrReq.data;
        ADDR_REF_OSC:    referenceOscillatorSetup <= wrReq.data;
        default: ;
      endcase
    end
  end

  // Pins only; nothing here feeds the conversion path
  assign ioOut = digitalIoPinLevels[3:0];
  assign ioOe  = digitalIoDirection[3:0];

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oscAsRef     <= 1'b0;
      referenceOn  <= 1'b0;
      bufferOn     <= 1'b0;
      refVoltSel   <= 2'h0;
      fullScale2v5 <= 1'b0;
    end else begin
      oscAsRef     <= referenceOscillatorSetup[OSC_AS_REF_BIT];
      referenceOn  <= referenceOscillatorSetup[REFERENCE_ON_BIT];
      bufferOn     <= referenceOscillatorSetup[BUFFER_ON_BIT];
      refVoltSel   <= {referenceOscillatorSetup[REF_VSEL_A_BIT],
                       referenceOscillatorSetup[REF_VSEL_B_BIT]};
      fullScale2v5 <= referenceOscillatorSetup[REFERENCE_ON_BIT]
                      && referenceOscillatorSetup[REF_VSEL_A_BIT:REF_VSEL_B_BIT] == 2'h0;
    end
  end

  logic [7:0] divCnt;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt     <= '0;
      convClkOut <= 1'b0;
    end else if (!referenceOscillatorSetup[OSC_POWER_BIT]) begin
      divCnt     <= '0;
      convClkOut <= 1'b0;
    end else if (divCnt == 8'(CONV_CLK_HALF - 1)) begin
      divCnt     <= '0;
      convClkOut <= !convClkOut;
    end else begin
      divCnt <= 8'(divCnt + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------
  // A full FIFO holds off the next start, so no result is ever dropped
  logic          pending;
  logic [15:0]   convCnt;
  logic          startConv;
  logic          doneConv;
  logic          fifoInReady;
  sadcs_result_t result;

  assign startConv = !busy && fifoInReady && (pending || cmdEvent);
  assign doneConv  = busy && (convCnt == 16'(CONV_CYCLES - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy        <= 1'b0;
      pending     <= 1'b0;
      convCnt     <= '0;
      convChannel <= '0;
      convGain    <= '0;
    end else begin
      if (startConv) begin
        busy        <= 1'b1;
        convCnt     <= '0;
        convChannel <= cmdByte[3:0];
        convGain    <= cmdByte[CMD_GAIN_LSB +: 3];
        pending     <= pending && cmdEvent;
      end else begin
        if (cmdEvent) begin
          pending <= 1'b1;
        end
        if (doneConv) begin
          busy <= 1'b0;
        end else if (busy) begin
          convCnt <= 16'(convCnt + 1'b1);
        end
      end
    end
  end

  assign result = '{code: codeS2, zero: 3'h0, overRange: 1'b0};

  logic          fifoOutValid;
  logic          fifoOutReady;
  logic [15:0]   fifoOutData;
  logic          offered;

  sadcs_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) resultFifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .inValid  (doneConv),
    .inReady  (fifoInReady),
    .inData   (result),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  assign fifoOutReady = !offered;

  // The word stays still while offered, so the link may read it freely.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      readyWord <= WORD_ZERO;
      pubToggle <= 1'b0;
      offered   <= 1'b0;
    end else if (!offered && fifoOutValid) begin
      readyWord <= fifoOutData;
      pubToggle <= !pubToggle;
      offered   <= 1'b1;
    end else if (offered && ackS2 == pubToggle) begin
      offered <= 1'b0;
    end
  end

endmodule : sadcs_converter_port

`default_nettype wire

// ===== verif/sadcs_ctrl_model.sv
// Behavioural serial controller driving the converter link
`timescale 1ns/1ps
`default_nettype none

module sadcs_ctrl_model (
  output logic      sclk,
  output logic      frameSel_b,
  output logic      din,
  input  wire logic dout
);
  // Link clock stands still between frames
  initial begin
    sclk       = 1'b0;
    frameSel_b = 1'b1;
    din        = 1'b1;
  end

  task automatic shiftBits(input logic [31:0] bits, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i < n; i++) begin
      din = bits[n-1-i];
      #7.5;
      if (i >= 8 && i < 24)
        rx[23-i] = dout;
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
  endtask : shiftBits

  task automatic endFrame();
    #7.5;
    frameSel_b = 1'b1;
    // Released line must not keep showing its last bit
    din = ~din;
  endtask : endFrame

  task automatic regWrite(input logic [7:0] instr, input logic [7:0] data);
    logic [15:0] rx;
    frameSel_b = 1'b0;
    #7.5;
    shiftBits({instr, data, ~instr, ~data}, 32, rx);
    endFrame();
    #120; // Wait state for resync
  endtask : regWrite

  // Stays selected so a chained command starts on the 25th edge
  task automatic directFrame(input logic [7:0] cmd, output logic [15:0] rx);
    if (frameSel_b) begin
      frameSel_b = 1'b0;
      #7.5;
    end
    shiftBits({8'h00, cmd, ~cmd, cmd}, 24, rx);
  endtask : directFrame
endmodule : sadcs_ctrl_model

`default_nettype wire

// ===== verif/sadcs_port_assertions.sv
// Concurrent checks on the converter port outputs
`timescale 1ns/1ps
`default_nettype none

module sadcs_port_checker
  import sadcs_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DFLT,
  parameter int FIFO_DEPTH  = 8
) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        sclk,
  input wire logic        frameSel_b,
  input wire logic        din,
  input wire logic        dout,
  input wire logic        busy,
  input wire logic [11:0] analogCode,
  input wire logic [3:0]  ioOut,
  input wire logic [3:0]  ioOe,
  input wire logic        convClkOut,
  input wire logic        oscAsRef,
  input wire logic        referenceOn,
  input wire logic        bufferOn,
  input wire logic [1:0]  refVoltSel,
  input wire logic        fullScale2v5,
  input wire logic [3:0]  convChannel,
  input wire logic [2:0]  convGain
);
  int         busyCnt;
  logic [7:0] clkRun;
  logic       clkArmed;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      busyCnt <= 0;
    else if (busy)
      busyCnt <= busyCnt + 1;
    else
      busyCnt <= 0;
  end

  // First edge after enable has no earlier edge to time its half period from
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clkRun   <= 8'h00;
      clkArmed <= 1'b0;
    end else if ($changed(convClkOut)) begin
      clkRun   <= 8'h01;
      clkArmed <= 1'b1;
    end else if (clkRun != 8'hFF)
      clkRun <= clkRun + 8'h01;
  end

  a_conv_clk_rate : assert property (
    $changed(convClkOut) && clkArmed |-> int'(clkRun) == CONV_CLK_HALF)
    else $error("conversion clock half period wrong");
  a_busy_len : assert property ($fell(busy) |-> busyCnt == CONV_CYCLES)
    else $error("busy length wrong");
  a_busy_max : assert property (busyCnt <= CONV_CYCLES)
    else $error("busy too long");
  a_full_scale : assert property (
    referenceOn && refVoltSel == 2'h0 |-> ##[0:1] fullScale2v5)
    else $error("full scale flag missing");
  a_scale_off : assert property (!referenceOn |-> ##[0:1] !fullScale2v5)
    else $error("full scale flag without reference");
  a_conv_setup : assert property (
    $rose(busy) |-> convChannel == 4'h8 && convGain == 3'h0)
    else $error("conversion channel or gain wrong");
  a_dout_idle : assert property (frameSel_b [*3] |-> !dout)
    else $error("data out not low outside frame");
  a_regs_hold : assert property (
    frameSel_b [*8] |=> $stable(ioOut) && $stable(ioOe) && $stable(referenceOn))
    else $error("register outputs moved outside frame");
endmodule : sadcs_port_checker

bind sadcs_converter_port sadcs_port_checker #(
  .CONV_CYCLES(CONV_CYCLES),
  .FIFO_DEPTH (FIFO_DEPTH)
) i_sadcs_port_checker (
  .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .frameSel_b(frameSel_b), .din(din),
  .dout(dout), .busy(busy), .analogCode(analogCode), .ioOut(ioOut), .ioOe(ioOe),
  .convClkOut(convClkOut), .oscAsRef(oscAsRef), .referenceOn(referenceOn),
  .bufferOn(bufferOn), .refVoltSel(refVoltSel), .fullScale2v5(fullScale2v5),
  .convChannel(convChannel), .convGain(convGain)
);

`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sadcs_pkg::*;
  localparam int CONV_N = 20;

  logic        mclk, rst_b, sclk, frameSel_b, din, dout, busy, convClkOut;
  logic        oscAsRef, referenceOn, bufferOn, fullScale2v5, seen;
  logic [11:0] analogCode, nextCode;
  logic [3:0]  ioOut, ioOe, convChannel;
  logic [2:0]  convGain;
  logic [1:0]  refVoltSel;
  logic [7:0]  d;
  logic [15:0] rx;
  logic [11:0] codes [6];
  logic [7:0]  badInstr [4] = '{8'h00, 8'h01, 8'h04, 8'h03};
  int          failCount, cmpCount, convCount;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sadcs_converter_port #(.CONV_CYCLES(CONV_N), .FIFO_DEPTH(8)) i_sadcs_converter_port (
    .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .frameSel_b(frameSel_b), .din(din),
    .dout(dout), .busy(busy), .analogCode(analogCode), .ioOut(ioOut), .ioOe(ioOe),
    .convClkOut(convClkOut), .oscAsRef(oscAsRef), .referenceOn(referenceOn),
    .bufferOn(bufferOn), .refVoltSel(refVoltSel), .fullScale2v5(fullScale2v5),
    .convChannel(convChannel), .convGain(convGain));
  sadcs_ctrl_model i_sadcs_ctrl_model (
    .sclk(sclk), .frameSel_b(frameSel_b), .din(din), .dout(dout));

  always @(posedge busy) begin
    if (rst_b)
      convCount++;
  end

  function automatic logic [15:0] resultWord(input logic [11:0] code);
    return {code, 3'h0, 1'b0};
  endfunction : resultWord

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkVal

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : endOfTest

  task automatic doReset();
    @(posedge mclk);
    #1 rst_b = 1'b0;
    repeat (12) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chkVal({ioOut, ioOe, convChannel, convGain, busy}, 16'h0000);
    chkVal({10'h000, oscAsRef, referenceOn, bufferOn, refVoltSel, fullScale2v5}, 16'h0000);
  endtask : doReset

  // Hang guard
  initial begin
    #200000;
    failCount++;
    endOfTest();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rst_b      = 1'b0;
    analogCode = 12'h000;
    void'($urandom(79950));
    doReset();
    i_sadcs_ctrl_model.regWrite(INSTR_WR_DIR, 8'h0F);
    chkVal({12'h000, ioOe}, 16'h000F);
    i_sadcs_ctrl_model.regWrite(INSTR_WR_LEVELS, 8'h05);
    chkVal({12'h000, ioOut}, 16'h0005);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      i_sadcs_ctrl_model.regWrite(INSTR_WR_LEVELS, d);
      chkVal({12'h000, ioOut}, {12'h000, d[3:0]});
      // Unknown instruction must leave the levels alone
      i_sadcs_ctrl_model.regWrite(badInstr[k], ~d);
      chkVal({12'h000, ioOut}, {12'h000, d[3:0]});
    end
    i_sadcs_ctrl_model.regWrite(INSTR_WR_REF_OSC, 8'h3C);
    chkVal({10'h000, oscAsRef, referenceOn, bufferOn, refVoltSel, fullScale2v5},
           16'h0039);
    seen = 1'b0;
    for (int i = 0; i < 100 && !seen; i++) begin
      @(posedge mclk);
      #1 seen = convClkOut;
    end
    chkVal({15'h0000, seen}, 16'h0001);
    // Chained frames without looking at busy
    for (int k = 0; k < 6; k++) begin
      codes[k] = (k == 1) ? 12'hFFF : 12'($urandom);
      nextCode = codes[k];
      fork
        begin
          @(posedge mclk);
          #1 analogCode = nextCode;
        end
      join_none
      i_sadcs_ctrl_model.directFrame(8'h88, rx);
      chkVal(rx, (k == 0) ? 16'h0000 : resultWord(codes[k-1]));
    end
    i_sadcs_ctrl_model.endFrame();
    for (int i = 0; i < 500 && busy !== 1'b0; i++)
      @(posedge mclk);
    chkVal({15'h0000, busy}, 16'h0000);
    chkVal(16'(convCount), 16'h0006);
    chkVal({9'h000, convChannel, convGain}, 16'h0040);
    doReset();
    endOfTest();
  end
endmodule : tb_top

`default_nettype wire
